// ---- shared/ulsm_pkg.sv ----
/*
 package of the line status and modem control block: register offsets,
 field positions, reset values, identification codes, states, received character type.
 assumes nothing of its surroundings.
*/
package ulsm_pkg;
   // ------------------------------------------------------------
   // register offsets on the three-bit register select
   // ------------------------------------------------------------
   localparam logic [2:0] OFS_DATA = 3'h0;
   localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
   localparam logic [2:0] OFS_INT_IDENT = 3'h2;
   localparam logic [2:0] OFS_LINE_CONTROL = 3'h3;
   localparam logic [2:0] OFS_MODEM_CONTROL = 3'h4;
   localparam logic [2:0] OFS_LINE_STATUS = 3'h5;
   localparam logic [2:0] OFS_MODEM_STATUS = 3'h6;
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int LCR_STOP = 2;
   localparam int LCR_PEN = 3;
   localparam int LCR_EVEN = 4;
   localparam int LCR_STICK = 5;
   localparam int LCR_BRK = 6;
   localparam int LCR_DIVISOR_ACCESS_BIT = 7;
   localparam int MCR_DTR = 0;
   localparam int MCR_RTS = 1;
   localparam int MCR_UA = 2;
   localparam int MCR_UB = 3;
   localparam int MCR_LOOP = 4;
   localparam int IER_RX = 0;
   localparam int IER_TX_HOLD_EMPTY_FLAG = 1;
   localparam int IER_LS = 2;
   localparam int IER_MS = 3;
   localparam logic [2:0] WLS_BASE = 3'h4;
   // ------------------------------------------------------------
   // reset values and identification codes
   // ------------------------------------------------------------
   localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
   localparam logic [4:0] MODEM_CONTROL_RST = 5'h00;
   localparam logic [3:0] INT_ENABLE_RST = 4'h0;
   localparam logic [2:0] ID_NONE = 3'h1;
   localparam logic [2:0] ID_LS = 3'h6;
   localparam logic [2:0] ID_RXD = 3'h4;
   localparam logic [2:0] ID_TX_HOLD_EMPTY_FLAG = 3'h2;
   localparam logic [2:0] ID_MS = 3'h0;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic brk;
      logic frame_err;
      logic parity_err;
      logic [7:0] data;
   } ulsm_rx_char_type;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ulsm_tx_state_type;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_PUSH,
      RX_WAIT_MARK} ulsm_rx_state_type;
endpackage

// ---- logic/ulsm_line_modem.sv ----
/*
 line status, modem control, character engines and loopback of a byte-wide
 asynchronous serial controller, with a two-entry receive buffer.
 assumes one-cycle read and write strobes synchronous to clk_in and a
 serial rate of one bit per CLKS_PER_BIT clocks.
*/
`timescale 1ns/1ns

module ulsm_pair_buf import ulsm_pkg::*; #(
   parameter int DEPTH = 2
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire ulsm_rx_char_type in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output ulsm_rx_char_type out_data_out
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   ulsm_rx_char_type mem_r [DEPTH];
   logic [PW-1:0] wp_r, rp_r;
   logic [PW:0] cnt_r;
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   assign in_ready_out = cnt_r != (PW+1)'(DEPTH);
   assign out_valid_out = cnt_r != '0;
   assign out_data_out = mem_r[rp_r];
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_entry
         always_ff @(posedge clk_in) begin
            if (push && wp_r == PW'(g)) mem_r[g] <= in_data_in;
         end
      end
   endgenerate
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop) rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // ulsm_pair_buf

module ulsm_line_modem import ulsm_pkg::*; #(
   parameter int CLKS_PER_BIT = 16
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic [2:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [7:0] wr_data_in,
   output logic [7:0] rd_data_out,
   output logic irq_out,
   input wire logic serial_rx_pin_in,
   output logic serial_tx_pin_out,
   input wire logic clear_send_n_in,
   input wire logic set_ready_n_in,
   input wire logic ring_n_in,
   input wire logic carrier_n_in,
   output logic term_ready_n_out,
   output logic req_send_n_out,
   output logic user_output_a_n_out,
   output logic user_output_b_n_out
);
   localparam logic [15:0] BIT_END = 16'(CLKS_PER_BIT - 1);
   localparam logic [15:0] HALF_END = 16'(CLKS_PER_BIT / 2 - 1);
   // ------------------------------------------------------------
   // registers and bus decode
   // ------------------------------------------------------------
   logic [7:0] lcr_r, tx_hold_r, rx_buffer_r, rd_data_r, tx_sh_r, rx_sh_r;
   logic [4:0] mcr_r;
   logic [3:0] ier_r, ms_prev_r, delta_r;
   logic dr_r, oe_r, pe_r, fe_r, bi_r, tx_hold_empty_flag_r, tx_hold_empty_flag_irq_r, irq_r, tx_pin_r;
   logic [3:0] modem_pins_r;
   ulsm_tx_state_type tx_st_r;
   ulsm_rx_state_type rx_st_r;
   logic [15:0] tx_cnt_r, rx_cnt_r;
   logic [2:0] tx_bit_r, rx_bit_r;
   logic tx_par_r, rx_pbit_r;
   ulsm_rx_char_type rx_char_r, buf_out;
   logic buf_in_ready, buf_out_valid;

   wire divisor_access_bit = lcr_r[LCR_DIVISOR_ACCESS_BIT];
   wire loop = mcr_r[MCR_LOOP];
   wire rd_rbr = rd_in && addr_in == OFS_DATA && !divisor_access_bit;
   wire wr_thr = wr_in && addr_in == OFS_DATA && !divisor_access_bit;
   wire wr_ier = wr_in && addr_in == OFS_INT_ENABLE && !divisor_access_bit;
   wire rd_iir = rd_in && addr_in == OFS_INT_IDENT;
   wire wr_lcr = wr_in && addr_in == OFS_LINE_CONTROL;
   wire wr_mcr = wr_in && addr_in == OFS_MODEM_CONTROL;
   wire rd_lsr = rd_in && addr_in == OFS_LINE_STATUS;
   wire rd_msr = rd_in && addr_in == OFS_MODEM_STATUS;

   // word length, mask and parity
   wire [2:0] last_idx = 3'(lcr_r[1:0]) + WLS_BASE;
   wire [7:0] word_mask = 8'hFF >> (3'h3 - 3'(lcr_r[1:0]));
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] l);
      if (l[LCR_STICK]) return !l[LCR_EVEN];
      return l[LCR_EVEN] ? ^d : ~^d;
   endfunction

   // ------------------------------------------------------------
   // line status flags
   // ------------------------------------------------------------
   wire load = buf_out_valid && !rd_rbr;
   wire tx_take = tx_st_r == TX_IDLE && !tx_hold_empty_flag_r;
   wire tx_all_empty_flag = tx_hold_empty_flag_r && tx_st_r == TX_IDLE;
   wire dr_nxt = load || (dr_r && !rd_rbr);
   wire oe_nxt = (load && dr_r) || (oe_r && !rd_lsr);
   wire pe_nxt = (load && buf_out.parity_err) || (pe_r && !rd_lsr);
   wire fe_nxt = (load && buf_out.frame_err) || (fe_r && !rd_lsr);
   wire bi_nxt = (load && buf_out.brk) || (bi_r && !rd_lsr);
   wire tx_hold_empty_flag_nxt = wr_thr ? 1'b0 : (tx_take || tx_hold_empty_flag_r);
   wire [7:0] line_status = {1'b0, tx_all_empty_flag, tx_hold_empty_flag_r, bi_r, fe_r, pe_r, oe_r, dr_r};

   // ------------------------------------------------------------
   // modem status and interrupt identification
   // ------------------------------------------------------------
   wire [3:0] ms_now = loop ? {mcr_r[MCR_UB], mcr_r[MCR_UA], mcr_r[MCR_DTR], mcr_r[MCR_RTS]}
      : ~{carrier_n_in, ring_n_in, set_ready_n_in, clear_send_n_in};
   wire [3:0] ms_chg = {ms_now[3] ^ ms_prev_r[3], ms_prev_r[2] & !ms_now[2],
      ms_now[1:0] ^ ms_prev_r[1:0]};
   wire [3:0] delta_nxt = ms_chg | (delta_r & {4{!rd_msr}});
   wire ls_pend = ier_r[IER_LS] && (oe_r || pe_r || fe_r || bi_r);
   wire rx_pend = ier_r[IER_RX] && dr_r;
   wire th_pend = ier_r[IER_TX_HOLD_EMPTY_FLAG] && tx_hold_empty_flag_irq_r;
   wire ms_pend = ier_r[IER_MS] && delta_r != 4'h0;
   wire [2:0] ident = ls_pend ? ID_LS : rx_pend ? ID_RXD : th_pend ? ID_TX_HOLD_EMPTY_FLAG
      : ms_pend ? ID_MS : ID_NONE;
   wire th_set = (tx_take && !wr_thr) || (wr_ier && wr_data_in[IER_TX_HOLD_EMPTY_FLAG] && tx_hold_empty_flag_r);
   wire th_clr = wr_thr || (rd_iir && ident == ID_TX_HOLD_EMPTY_FLAG);
   wire tx_hold_empty_flag_irq_nxt = th_set || (tx_hold_empty_flag_irq_r && !th_clr);

   wire [7:0] rd_mux =
      (addr_in == OFS_DATA) ? (divisor_access_bit ? 8'h00 : rx_buffer_r) :
      (addr_in == OFS_INT_ENABLE) ? (divisor_access_bit ? 8'h00 : {4'h0, ier_r}) :
      (addr_in == OFS_INT_IDENT) ? {5'h00, ident} :
      (addr_in == OFS_LINE_CONTROL) ? lcr_r :
      (addr_in == OFS_MODEM_CONTROL) ? {3'h0, mcr_r} :
      (addr_in == OFS_LINE_STATUS) ? line_status :
      (addr_in == OFS_MODEM_STATUS) ? {ms_now, delta_r} : 8'h00;

   // ------------------------------------------------------------
   // serial lines
   // ------------------------------------------------------------
   wire tx_bit_val = (tx_st_r == TX_START) ? 1'b0 : (tx_st_r == TX_DATA) ? tx_sh_r[tx_bit_r]
      : (tx_st_r == TX_PAR) ? tx_par_r : 1'b1;
   wire tx_line = lcr_r[LCR_BRK] ? 1'b0 : tx_bit_val;
   wire rx_line = loop ? tx_line : serial_rx_pin_in;
   wire tx_end = tx_cnt_r == BIT_END;
   wire rx_end = rx_cnt_r == BIT_END;
   wire [7:0] rx_mask = rx_sh_r & word_mask;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         lcr_r <= LINE_CONTROL_RST;
         mcr_r <= MODEM_CONTROL_RST;
         ier_r <= INT_ENABLE_RST;
         {dr_r, oe_r, pe_r, fe_r, bi_r} <= 5'h00;
         tx_hold_empty_flag_r <= 1'b1;
         tx_hold_empty_flag_irq_r <= 1'b0;
         ms_prev_r <= 4'h0;
         delta_r <= 4'h0;
         irq_r <= 1'b0;
         rd_data_r <= 8'h00;
         tx_hold_r <= 8'h00;
         rx_buffer_r <= 8'h00;
      end else begin
         if (wr_lcr) lcr_r <= wr_data_in;
         if (wr_mcr) mcr_r <= wr_data_in[4:0];
         if (wr_ier) ier_r <= wr_data_in[3:0];
         if (wr_thr) tx_hold_r <= wr_data_in;
         if (load) rx_buffer_r <= buf_out.data;
         {dr_r, oe_r, pe_r, fe_r, bi_r} <= {dr_nxt, oe_nxt, pe_nxt, fe_nxt, bi_nxt};
         tx_hold_empty_flag_r <= tx_hold_empty_flag_nxt;
         tx_hold_empty_flag_irq_r <= tx_hold_empty_flag_irq_nxt;
         ms_prev_r <= ms_now;
         delta_r <= delta_nxt;
         irq_r <= ls_pend || rx_pend || th_pend || ms_pend;
         if (rd_in) rd_data_r <= rd_mux;
      end
   end

   // pins come straight from flops; loopback forces them inactive
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         modem_pins_r <= 4'hF;
         tx_pin_r <= 1'b1;
      end else begin
         modem_pins_r <= loop ? 4'hF : ~mcr_r[3:0];
         tx_pin_r <= loop ? 1'b1 : tx_line;
      end
   end

   // ------------------------------------------------------------
   // transmit engine
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         tx_st_r <= TX_IDLE;
         tx_cnt_r <= '0;
         tx_bit_r <= '0;
         tx_sh_r <= 8'h00;
         tx_par_r <= 1'b0;
      end else begin
         tx_cnt_r <= (tx_st_r == TX_IDLE || tx_end) ? '0 : tx_cnt_r + 16'h1;
         unique case (tx_st_r)
            TX_IDLE: if (tx_take) begin
               tx_sh_r <= tx_hold_r & word_mask;
               tx_par_r <= par_bit(tx_hold_r & word_mask, lcr_r);
               tx_st_r <= TX_START;
            end
            TX_START: if (tx_end) begin
               tx_bit_r <= '0;
               tx_st_r <= TX_DATA;
            end
            TX_DATA: if (tx_end) begin
               tx_bit_r <= tx_bit_r + 3'h1;
               if (tx_bit_r == last_idx) begin
                  tx_bit_r <= '0;
                  tx_st_r <= lcr_r[LCR_PEN] ? TX_PAR : TX_STOP;
               end
            end
            TX_PAR: if (tx_end) tx_st_r <= TX_STOP;
            TX_STOP: if (tx_end) begin
               tx_bit_r <= tx_bit_r + 3'h1;
               if (tx_bit_r != 3'(lcr_r[LCR_STOP])) tx_st_r <= TX_STOP;
               else tx_st_r <= TX_IDLE;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // receive engine and two-entry buffer
   // ------------------------------------------------------------
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         rx_st_r <= RX_IDLE;
         rx_cnt_r <= '0;
         rx_bit_r <= '0;
         rx_sh_r <= 8'h00;
         rx_pbit_r <= 1'b0;
         rx_char_r <= '0;
      end else begin
         rx_cnt_r <= (rx_st_r == RX_IDLE || rx_end) ? '0 : rx_cnt_r + 16'h1;
         unique case (rx_st_r)
            RX_IDLE: if (!rx_line) begin
               rx_sh_r <= 8'h00;
               rx_pbit_r <= 1'b0;
               rx_st_r <= RX_START;
            end
            RX_START: if (rx_cnt_r == HALF_END) begin
               rx_cnt_r <= '0;
               rx_bit_r <= '0;
               rx_st_r <= rx_line ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_end) begin
               rx_sh_r[rx_bit_r] <= rx_line;
               rx_bit_r <= rx_bit_r + 3'h1;
               if (rx_bit_r == last_idx) rx_st_r <= lcr_r[LCR_PEN] ? RX_PAR : RX_STOP;
            end
            RX_PAR: if (rx_end) begin
               rx_pbit_r <= rx_line;
               rx_st_r <= RX_STOP;
            end
            RX_STOP: if (rx_end) begin
               rx_char_r.data <= rx_mask;
               rx_char_r.frame_err <= !rx_line;
               rx_char_r.parity_err <= lcr_r[LCR_PEN]
                  && rx_pbit_r != par_bit(rx_mask, lcr_r);
               rx_char_r.brk <= !rx_line && rx_mask == 8'h00 && !rx_pbit_r;
               rx_st_r <= RX_PUSH;
            end
            RX_PUSH: if (buf_in_ready) rx_st_r <= rx_char_r.frame_err ? RX_WAIT_MARK : RX_IDLE;
            RX_WAIT_MARK: if (rx_line) rx_st_r <= RX_IDLE;
            default: rx_st_r <= RX_IDLE;
         endcase
      end
   end

   ulsm_pair_buf #(.DEPTH(2)) u_rx_buf (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .in_valid_in(rx_st_r == RX_PUSH),
      .in_ready_out(buf_in_ready),
      .in_data_in(rx_char_r),
      .out_valid_out(buf_out_valid),
      .out_ready_in(!rd_rbr),
      .out_data_out(buf_out)
   );

   assign rd_data_out = rd_data_r;
   assign irq_out = irq_r;
   assign serial_tx_pin_out = tx_pin_r;
   assign {user_output_b_n_out, user_output_a_n_out, req_send_n_out, term_ready_n_out}
      = modem_pins_r;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   a_status_bit_seven: assert property (rd_lsr |=> rd_data_out[7] == 1'b0)
      else $error("status bit 7 read as one");
   a_status_read_clear: assert property (rd_lsr && !load |=> !oe_r && !pe_r && !fe_r && !bi_r)
      else $error("status read left an error flag set");
   a_overrun_on_load: assert property (load && dr_r |=> oe_r && dr_r)
      else $error("overwrite of unread character without overrun");
   a_ready_read_clear: assert property (rd_rbr |=> !dr_r)
      else $error("buffer read did not clear ready");
   a_hold_write_clear: assert property (wr_thr |=> !tx_hold_empty_flag_r ##0 !tx_all_empty_flag)
      else $error("holding write did not clear empty flags");
   a_all_empty_needs: assert property (line_status[6] && !lcr_r[LCR_BRK] |=> serial_tx_pin_out)
      else $error("all-empty set while the line is not marking");
   a_loop_tx_mark: assert property (loop ##1 loop |-> serial_tx_pin_out)
      else $error("serial output not marking in loopback");
   a_loop_pins_high: assert property (loop |=> modem_pins_r == 4'hF)
      else $error("modem pins active in loopback");
   a_pin_inverted: assert property (!loop |=> term_ready_n_out == !$past(mcr_r[MCR_DTR]))
      else $error("terminal-ready pin not inverted from its bit");
   a_line_irq: assert property (ier_r[IER_LS] && (oe_r || fe_r) |=> irq_out)
      else $error("line status interrupt missing");
   a_set_beats_clear: assert property (rd_lsr && load && buf_out.frame_err |=> fe_r)
      else $error("framing flag lost to a same-cycle read");
endmodule // ulsm_line_modem

// ---- tb/ulsm_modem_model.sv ----
/*
 modem side model: sends characters into the receiver, decodes the
 transmitter's output, drives the four modem inputs.
 assumes the bench calls its tasks just after a falling clock edge.
*/
`timescale 1ns/1ns
module ulsm_modem_model #(
   parameter int CPB = 4
) (
   input wire logic clk_in,
   input wire logic line_in,
   output logic line_out,
   output logic [3:0] modem_n_out
);
   int nbits = 8;
   bit par_en = 1'b0;
   bit par_even = 1'b0;
   logic [7:0] got_q[$];
   logic [7:0] rx_d;
   initial begin
      line_out = 1'b1;
      modem_n_out = 4'hF;
   end
   // ------------------------------------------------------------
   // sending side
   // ------------------------------------------------------------
   task automatic put_bit(input logic b, input int n);
      line_out = b;
      repeat (n * CPB) @(negedge clk_in);
   endtask
   task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
      put_bit(1'b0, 1);
      for (int i = 0; i < nbits; i++) begin
         put_bit(d[i], 1);
      end
      if (par_en) begin
         put_bit((^d) ^ !par_even ^ bad_par, 1);
      end
      put_bit(!bad_stop, 1);
      put_bit(1'b1, 2);
   endtask
   task automatic send_break();
      put_bit(1'b0, nbits + 4);
      put_bit(1'b1, 2);
   endtask
   // ------------------------------------------------------------
   // receiving side
   // ------------------------------------------------------------
   initial forever begin
      @(negedge clk_in);
      if (line_in === 1'b0) begin
         rx_d = 8'h00;
         repeat (CPB / 2) @(negedge clk_in);
         for (int i = 0; i < nbits; i++) begin
            repeat (CPB) @(negedge clk_in);
            rx_d[i] = line_in;
         end
         repeat ((par_en + 1) * CPB) @(negedge clk_in);
         got_q.push_back(rx_d);
      end
   end
endmodule // ulsm_modem_model

// ---- tb/tb_top.sv ----
/*
 self-checking bench of the line status and modem control block.
 assumes the modem model on the serial side and CLKS_PER_BIT of 4.
*/
`timescale 1ns/1ns
module tb_top;
   import ulsm_pkg::*;
   localparam int CPB = 4;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic rd_in = 1'b0;
   logic wr_in = 1'b0;
   logic [7:0] wr_data_in = 8'h00;
   logic [7:0] rd_data_out;
   logic irq_out, ser_rx, ser_tx;
   logic [3:0] modem_n, ctl_n;
   int n_errors = 0;
   int n_checks = 0;
   integer seed = 32'hC2A20AC2;
   int m_dr = 0, m_oe = 0, m_pe = 0, m_fe = 0, m_bi = 0;
   logic [7:0] m_buf, rv, d, mask;
   int i, k;
   bit in_loop = 1'b0;
   always #2 clk_in = ~clk_in;
   ulsm_line_modem #(.CLKS_PER_BIT(CPB)) u_dut (
      .clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in), .rd_in(rd_in),
      .wr_in(wr_in), .wr_data_in(wr_data_in), .rd_data_out(rd_data_out),
      .irq_out(irq_out), .serial_rx_pin_in(ser_rx), .serial_tx_pin_out(ser_tx),
      .clear_send_n_in(modem_n[0]), .set_ready_n_in(modem_n[1]),
      .ring_n_in(modem_n[2]), .carrier_n_in(modem_n[3]),
      .term_ready_n_out(ctl_n[0]), .req_send_n_out(ctl_n[1]),
      .user_output_a_n_out(ctl_n[2]), .user_output_b_n_out(ctl_n[3])
   );
   ulsm_modem_model #(.CPB(CPB)) u_modem (
      .clk_in(clk_in), .line_in(ser_tx), .line_out(ser_rx), .modem_n_out(modem_n)
   );
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic close_out();
      if (n_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp,
         input logic [7:0] msk, input string what);
      n_checks++;
      if ((got & msk) !== (exp & msk)) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic timeout(input string what);
      n_errors++;
      $display("mismatch at %0t: %s timed out", $time, what);
      close_out();
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] v);
      @(negedge clk_in);
      addr_in = a;
      wr_data_in = v;
      wr_in = 1'b1;
      @(negedge clk_in);
      wr_in = 1'b0;
   endtask
   task automatic reg_rd(input logic [2:0] a, output logic [7:0] v);
      @(negedge clk_in);
      addr_in = a;
      rd_in = 1'b1;
      @(negedge clk_in);
      rd_in = 1'b0;
      v = rd_data_out;
   endtask
   // ------------------------------------------------------------
   // receive model
   // ------------------------------------------------------------
   task automatic m_load(input logic [7:0] v, input int pe, input int fe, input int bi);
      m_oe |= m_dr;
      m_dr = 1;
      m_buf = v;
      m_pe |= pe;
      m_fe |= fe;
      m_bi |= bi;
   endtask
   task automatic chk_status(input logic [7:0] msk);
      reg_rd(OFS_LINE_STATUS, rv);
      check(rv, {3'b011, m_bi[0], m_fe[0], m_pe[0], m_oe[0], m_dr[0]}, msk, "status");
      m_oe = 0;
      m_pe = 0;
      m_fe = 0;
      m_bi = 0;
   endtask
   task automatic chk_buf();
      reg_rd(OFS_DATA, rv);
      check(rv, m_buf, 8'hFF, "buffer");
      m_dr = 0;
   endtask
   task automatic wait_idle();
      for (k = 0; k < 300; k++) begin
         reg_rd(OFS_LINE_STATUS, rv);
         if (in_loop) check({7'h00, ser_tx}, 8'h01, 8'hFF, "loop pin");
         if (rv[6] === 1'b1) break;
      end
      if (k == 300) timeout("transmitter");
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge clk_in);
      nrst_in = 1'b1;
      chk_status(8'hFF);
      reg_rd(OFS_MODEM_CONTROL, rv);
      check(rv, 8'h00, 8'hFF, "control reset");
      check({4'h0, ctl_n}, 8'h0F, 8'hFF, "pins reset");
      for (i = 0; i < 16; i++) begin
         d = 8'($random(seed));
         d[4] = 1'b0;
         reg_wr(OFS_MODEM_CONTROL, d);
         reg_rd(OFS_MODEM_CONTROL, rv);
         check(rv, {3'b000, d[4:0]}, 8'hFF, "control");
         check({4'h0, ctl_n}, {4'h0, ~d[3:0]}, 8'hFF, "pins");
      end
      for (i = 0; i < 8; i++) begin
         u_modem.nbits = 5 + (i % 4);
         u_modem.par_en = i[2];
         u_modem.par_even = i[0];
         mask = 8'hFF >> (3 - (i % 4));
         reg_wr(OFS_LINE_CONTROL, {3'b000, i[0], i[2], 1'b0, i[1:0]});
         d = 8'($random(seed)) & mask;
         u_modem.send(d, 1'b0, 1'b0);
         m_load(d, 0, 0, 0);
         chk_status(8'hFF);
         chk_buf();
         chk_status(8'h01);
         d = 8'($random(seed));
         reg_wr(OFS_DATA, d);
         reg_rd(OFS_LINE_STATUS, rv);
         check(rv, 8'h00, 8'hC0, "all empty low");
         for (k = 0; k < 600 && u_modem.got_q.size() == 0; k++) @(negedge clk_in);
         if (k == 600) timeout("modem receive");
         check(u_modem.got_q.pop_front(), d & mask, 8'hFF, "sent char");
         wait_idle();
      end
      reg_wr(OFS_LINE_CONTROL, 8'h1B);
      reg_wr(OFS_INT_ENABLE, 8'h04);
      u_modem.nbits = 8;
      u_modem.par_en = 1'b1;
      u_modem.par_even = 1'b1;
      d = 8'($random(seed));
      u_modem.send(d, 1'b1, 1'b0);
      m_load(d, 1, 0, 0);
      check({7'h00, irq_out}, 8'h01, 8'hFF, "line irq");
      chk_buf();
      d = 8'($random(seed));
      u_modem.send(d, 1'b0, 1'b0);
      m_load(d, 0, 0, 0);
      chk_status(8'hFF);
      @(negedge clk_in);
      check({7'h00, irq_out}, 8'h00, 8'hFF, "line irq off");
      chk_buf();
      d[0] = 1'b1;
      u_modem.send(d, 1'b0, 1'b1);
      m_load(d, 0, 1, 0);
      chk_status(8'hFF);
      chk_buf();
      u_modem.send_break();
      m_load(8'h00, 0, 1, 1);
      chk_status(8'hFF);
      chk_buf();
      for (i = 0; i < 2; i++) begin
         d = 8'($random(seed));
         u_modem.send(d, 1'b0, 1'b0);
         m_load(d, 0, 0, 0);
      end
      chk_status(8'hFF);
      chk_buf();
      reg_wr(OFS_INT_ENABLE, 8'h02);
      @(negedge clk_in);
      check({7'h00, irq_out}, 8'h01, 8'hFF, "empty irq");
      reg_rd(OFS_INT_IDENT, rv);
      check(rv, {5'h00, ID_TX_HOLD_EMPTY_FLAG}, 8'h07, "ident");
      @(negedge clk_in);
      check({7'h00, irq_out}, 8'h00, 8'hFF, "empty irq off");
      reg_wr(OFS_INT_ENABLE, 8'h00);
      reg_wr(OFS_MODEM_CONTROL, 8'h13);
      u_modem.put_bit(1'b0, 0);
      in_loop = 1'b1;
      reg_rd(OFS_MODEM_CONTROL, rv);
      check(rv, 8'h13, 8'hFF, "loop control");
      check({4'h0, ctl_n}, 8'h0F, 8'hFF, "loop pins");
      d = 8'($random(seed));
      reg_wr(OFS_DATA, d);
      wait_idle();
      repeat (2 * CPB) @(negedge clk_in);
      m_load(d, 0, 0, 0);
      chk_status(8'hFF);
      chk_buf();
      check(8'(u_modem.got_q.size()), 8'h00, 8'hFF, "loop leak");
      reg_rd(OFS_MODEM_STATUS, rv);
      check(rv, 8'h30, 8'hF0, "loop status");
      in_loop = 1'b0;
      u_modem.put_bit(1'b1, 0);
      reg_wr(OFS_MODEM_CONTROL, 8'h0F);
      @(negedge clk_in);
      nrst_in = 1'b0;
      repeat (2) @(negedge clk_in);
      nrst_in = 1'b1;
      check({4'h0, ctl_n}, 8'h0F, 8'hFF, "pins second reset");
      chk_status(8'hFF);
      close_out();
   end
endmodule // tb_top
